// *** hw/spc_pkg.sv ***
package spc_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 5000;
	localparam int LOOP_STEP_US = 1;
	localparam int LOOP_STEP_PS = LOOP_STEP_US * 1000000;
	localparam logic [7:0] CYC_PER_US = 8'(LOOP_STEP_PS / CLK_PERIOD_PS);

	// ------------------------------------------------------------
	// Limits and reset values
	// ------------------------------------------------------------
	localparam logic [19:0] LOOP_TIME_MIN = 20'h00001;
	localparam logic [19:0] LOOP_TIME_MAX = 20'hF4240;
	localparam logic [19:0] LOOP_NUM_MIN = 20'h00002;
	localparam logic [19:0] LOOP_NUM_MAX = 20'hF4240;
	localparam logic [16:0] OS_INTV_MIN = 17'h00001;
	localparam logic [16:0] OS_INTV_MAX = 17'h10000;
	localparam logic [7:0] BLOCK_MIN = 8'h01;
	localparam logic [7:0] BLOCK_MAX = 8'h80;
	localparam logic [23:0] SEED_8B10B = 24'h00FFFF;
	localparam logic [23:0] SEED_128B132B = 24'h1DBFBC;
	localparam logic [23:0] SEED_RST = 24'h000000;

	// ------------------------------------------------------------
	// Enumerations
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		SPC_SPEC_PCIE1 = 3'h0,
		SPC_SPEC_PCIE2 = 3'h1,
		SPC_SPEC_PCIE3 = 3'h2,
		SPC_SPEC_PCIE4 = 3'h3,
		SPC_SPEC_PCIE5 = 3'h4,
		SPC_SPEC_USB30 = 3'h5,
		SPC_SPEC_USB31G2 = 3'h6
	} spc_spec_t;

	typedef enum logic [1:0] {
		SPC_COD_8B10B = 2'h0,
		SPC_COD_128B130B = 2'h1,
		SPC_COD_128B132B = 2'h2
	} spc_coding_t;

	typedef enum logic [1:0] {
		SPC_BRK_OFF = 2'h0,
		SPC_BRK_LFPS = 2'h1,
		SPC_BRK_EDGE = 2'h2,
		SPC_BRK_MANUAL = 2'h3
	} spc_brk_t;

	typedef enum logic {
		SPC_LOOP_TIME = 1'h0,
		SPC_LOOP_NUM = 1'h1
	} spc_loop_t;

	typedef enum logic [1:0] {
		SPC_ST_IDLE = 2'h0,
		SPC_ST_RUN = 2'h1,
		SPC_ST_LOOP = 2'h2
	} spc_state_t;

	// ------------------------------------------------------------
	// Configuration carrier
	// ------------------------------------------------------------
	typedef struct packed {
		spc_spec_t spec;
		spc_coding_t coding;
		logic [2:0] lane;
		spc_brk_t brk;
		spc_loop_t loop_mode;
		logic [19:0] loop_time;
		logic [19:0] loop_num;
		logic skp_ins;
		logic skp_rst;
		logic eie_ins;
		logic eie_rst;
		logic [16:0] eie_intv;
		logic sync_ins;
		logic sync_rst;
		logic [16:0] sync_intv;
		logic [7:0] trig_block;
		logic [7:0] loop_block;
		logic [7:0] last_block;
		logic user_prbs_inv;
	} spc_cfg_t;

endpackage

// *** hw/spc_seq_ctrl.sv ***
`timescale 1ns/1ps
// Summary of operation
// RQ1 - Loop mode time or count applies only while the break source is off.
// RQ2 - Time looping repeats the block for 1 to 1000000 microseconds.
// RQ3 - Count looping repeats 2 to 1000000 times, always an even count.
// RQ4 - The LFPS break source is honoured only for USB specifications.
// RQ5 - EIEOSQ insert and reset switches; inserted every 1 to 65536 repeats.
// RQ6 - EIEOSQ insertion happens only for PCIe specifications.
// RQ7 - SYNC insert and reset switches; inserted every 1 to 65536 repeats.
// RQ8 - SYNC insertion happens only for USB3.1 Gen2.
// RQ9 - SKP insertion and SKP reset have independent switches.
// RQ10 - Scrambler seed FFFF for 8b10b, 1DBFBC for 128b132b, lane seed for 128b130b.
// RQ11 - A one-cycle trigger pulse marks entry into the chosen block 1 to 128.
// RQ12 - Transmit starts the sequence; the indicator stays lit while sending.
// RQ13 - Manual break commands count only when the manual source is chosen.
// RQ14 - Either channel in sequence mode forces the other into it.
// RQ15 - User four-level patterns may invert the pseudo-random raw data.
// RQ16 - Specification is one of PCIe1 to PCIe5, USB3.0 or USB3.1 Gen2.
// RQ17 - When the loop ends or breaks, the sequence moves to the next block.
module spc_seq_ctrl #(
	parameter logic [23:0] LANE_SEED_0 = 24'h000001,
	parameter logic [23:0] LANE_SEED_1 = 24'h000002,
	parameter logic [23:0] LANE_SEED_2 = 24'h000003,
	parameter logic [23:0] LANE_SEED_3 = 24'h000004,
	parameter logic [23:0] LANE_SEED_4 = 24'h000005,
	parameter logic [23:0] LANE_SEED_5 = 24'h000006,
	parameter logic [23:0] LANE_SEED_6 = 24'h000007,
	parameter logic [23:0] LANE_SEED_7 = 24'h000008
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire spc_pkg::spc_cfg_t cfg,
	input wire logic transmit_cmd,
	input wire logic stop_cmd,
	input wire logic manual_break_cmd,
	input wire logic ext_lfps_evt,
	input wire logic ext_edge_evt,
	input wire logic rep_done,
	input wire logic channel_one_seq_req,
	input wire logic channel_two_seq_req,
	input wire logic raw_bit,
	input wire logic raw_is_prbs,
	output logic tx_led,
	output logic loop_active,
	output logic [7:0] cur_block,
	output logic aux_trig,
	output logic skp_insert_en,
	output logic skp_cnt_clr,
	output logic eieosq_insert,
	output logic sync_insert,
	output logic [23:0] scr_seed,
	output logic channel_one_seq,
	output logic channel_two_seq,
	output logic raw_bit_out
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		spc_pkg::spc_state_t fsm;
		spc_pkg::spc_cfg_t cfg;
		logic [7:0] block;
		logic [19:0] loop_cnt;
		logic [19:0] us_cnt;
		logic [7:0] pre_cnt;
		logic brk_seen;
		logic [16:0] eie_cnt;
		logic [16:0] sync_cnt;
		logic tx_led;
		logic loop_active;
		logic aux_trig;
		logic skp_insert_en;
		logic skp_cnt_clr;
		logic eieosq_insert;
		logic sync_insert;
		logic [23:0] scr_seed;
		logic channel_one_seq;
		logic channel_two_seq;
		logic raw_bit_out;
	} spc_st_t;

	spc_st_t st_r;
	spc_st_t st_nxt;

	// ------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------
	function automatic logic [19:0] f_clamp20(input logic [19:0] v, input logic [19:0] lo, input logic [19:0] hi);
		logic [19:0] r;
		r = v;
		if (v < lo) begin
			r = lo;
		end else if (v > hi) begin
			r = hi;
		end
		return r;
	endfunction

	function automatic logic [16:0] f_clamp_intv(input logic [16:0] v);
		logic [16:0] r;
		r = v;
		if (v < spc_pkg::OS_INTV_MIN) begin
			r = spc_pkg::OS_INTV_MIN;
		end else if (v > spc_pkg::OS_INTV_MAX) begin
			r = spc_pkg::OS_INTV_MAX;
		end
		return r;
	endfunction

	function automatic logic [7:0] f_clamp_blk(input logic [7:0] v);
		logic [7:0] r;
		r = v;
		if (v < spc_pkg::BLOCK_MIN) begin
			r = spc_pkg::BLOCK_MIN;
		end else if (v > spc_pkg::BLOCK_MAX) begin
			r = spc_pkg::BLOCK_MAX;
		end
		return r;
	endfunction

	function automatic logic f_is_pcie(input spc_pkg::spc_spec_t s);
		return (s == spc_pkg::SPC_SPEC_PCIE1) || (s == spc_pkg::SPC_SPEC_PCIE2) ||
			(s == spc_pkg::SPC_SPEC_PCIE3) || (s == spc_pkg::SPC_SPEC_PCIE4) ||
			(s == spc_pkg::SPC_SPEC_PCIE5);
	endfunction

	function automatic logic f_is_usb(input spc_pkg::spc_spec_t s);
		return (s == spc_pkg::SPC_SPEC_USB30) || (s == spc_pkg::SPC_SPEC_USB31G2);
	endfunction

	function automatic spc_pkg::spc_spec_t f_legal_spec(input spc_pkg::spc_spec_t s);
		return (f_is_pcie(s) || f_is_usb(s)) ? s : spc_pkg::SPC_SPEC_PCIE1;
	endfunction

	// ------------------------------------------------------------
	// Derived values of the latched configuration and of the live lane setting
	// ------------------------------------------------------------
	logic [19:0] loop_time_eff;
	logic [19:0] loop_num_eff;
	logic [16:0] eie_intv_eff;
	logic [16:0] sync_intv_eff;
	logic [7:0] trig_blk_eff;
	logic [7:0] loop_blk_eff;
	logic [7:0] last_blk_eff;
	logic eie_allowed;
	logic sync_allowed;
	logic brk_evt;
	logic loop_exit;
	logic [23:0] lane_seed;

	always_comb begin
		loop_time_eff = f_clamp20(st_r.cfg.loop_time, spc_pkg::LOOP_TIME_MIN, spc_pkg::LOOP_TIME_MAX); // [RQ2]
		loop_num_eff = f_clamp20({st_r.cfg.loop_num[19:1], 1'b0}, spc_pkg::LOOP_NUM_MIN,
			spc_pkg::LOOP_NUM_MAX); // [RQ3]
		eie_intv_eff = f_clamp_intv(st_r.cfg.eie_intv); // [RQ5]
		sync_intv_eff = f_clamp_intv(st_r.cfg.sync_intv); // [RQ7]
		trig_blk_eff = f_clamp_blk(st_r.cfg.trig_block);
		loop_blk_eff = f_clamp_blk(st_r.cfg.loop_block);
		last_blk_eff = f_clamp_blk(st_r.cfg.last_block);
		eie_allowed = st_r.cfg.eie_ins && f_is_pcie(st_r.cfg.spec); // [RQ6]
		sync_allowed = st_r.cfg.sync_ins && (st_r.cfg.spec == spc_pkg::SPC_SPEC_USB31G2); // [RQ8]
		unique case (st_r.cfg.brk)
			spc_pkg::SPC_BRK_LFPS: brk_evt = ext_lfps_evt && f_is_usb(st_r.cfg.spec); // [RQ4]
			spc_pkg::SPC_BRK_EDGE: brk_evt = ext_edge_evt;
			spc_pkg::SPC_BRK_MANUAL: brk_evt = manual_break_cmd; // [RQ13]
			spc_pkg::SPC_BRK_OFF: brk_evt = 1'b0;
		endcase
		if (st_r.cfg.brk != spc_pkg::SPC_BRK_OFF) begin
			loop_exit = st_r.brk_seen || brk_evt;
		end else if (st_r.cfg.loop_mode == spc_pkg::SPC_LOOP_TIME) begin
			loop_exit = st_r.us_cnt >= loop_time_eff; // [RQ1] [RQ2]
		end else begin
			loop_exit = (st_r.loop_cnt + 20'h00001) >= loop_num_eff; // [RQ1] [RQ3]
		end
		unique case (cfg.lane)
			3'h0: lane_seed = LANE_SEED_0;
			3'h1: lane_seed = LANE_SEED_1;
			3'h2: lane_seed = LANE_SEED_2;
			3'h3: lane_seed = LANE_SEED_3;
			3'h4: lane_seed = LANE_SEED_4;
			3'h5: lane_seed = LANE_SEED_5;
			3'h6: lane_seed = LANE_SEED_6;
			3'h7: lane_seed = LANE_SEED_7;
		endcase
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic [7:0] nb;
		logic advance;
		nb = st_r.block;
		advance = 1'b0;
		st_nxt = st_r;
		st_nxt.aux_trig = 1'b0;
		st_nxt.skp_cnt_clr = 1'b0;
		st_nxt.eieosq_insert = 1'b0;
		st_nxt.sync_insert = 1'b0;

		st_nxt.channel_one_seq = channel_one_seq_req || channel_two_seq_req; // [RQ14]
		st_nxt.channel_two_seq = channel_one_seq_req || channel_two_seq_req; // [RQ14]
		st_nxt.raw_bit_out = raw_bit ^ (raw_is_prbs && cfg.user_prbs_inv); // [RQ15]

		unique case (st_r.fsm)
			spc_pkg::SPC_ST_IDLE: begin
				if (transmit_cmd) begin
					st_nxt.cfg = cfg;
					st_nxt.cfg.spec = f_legal_spec(cfg.spec); // [RQ16]
					st_nxt.tx_led = 1'b1; // [RQ12]
					st_nxt.eie_cnt = 17'h00000;
					st_nxt.sync_cnt = 17'h00000;
					unique case (cfg.coding)
						spc_pkg::SPC_COD_8B10B: st_nxt.scr_seed = spc_pkg::SEED_8B10B; // [RQ10]
						spc_pkg::SPC_COD_128B132B: st_nxt.scr_seed = spc_pkg::SEED_128B132B; // [RQ10]
						spc_pkg::SPC_COD_128B130B: st_nxt.scr_seed = lane_seed; // [RQ10]
						default: st_nxt.scr_seed = spc_pkg::SEED_8B10B;
					endcase
					nb = spc_pkg::BLOCK_MIN;
					advance = 1'b1; // [RQ12]
				end
			end
			spc_pkg::SPC_ST_RUN: begin
				if (rep_done) begin
					if (st_r.block >= last_blk_eff) begin
						nb = spc_pkg::BLOCK_MIN;
					end else begin
						nb = st_r.block + 8'h01;
					end
					advance = 1'b1;
				end
			end
			spc_pkg::SPC_ST_LOOP: begin
				if (st_r.pre_cnt == (spc_pkg::CYC_PER_US - 8'h01)) begin
					st_nxt.pre_cnt = 8'h00;
					if (st_r.us_cnt != spc_pkg::LOOP_TIME_MAX) begin
						st_nxt.us_cnt = st_r.us_cnt + 20'h00001; // [RQ2]
					end
				end else begin
					st_nxt.pre_cnt = st_r.pre_cnt + 8'h01;
				end
				if (brk_evt) begin
					st_nxt.brk_seen = 1'b1; // [RQ13]
				end
				if (rep_done) begin
					st_nxt.loop_cnt = st_r.loop_cnt + 20'h00001; // [RQ3]
					if (loop_exit) begin
						if (st_r.block >= last_blk_eff) begin
							nb = spc_pkg::BLOCK_MIN;
						end else begin
							nb = st_r.block + 8'h01;
						end
						advance = 1'b1; // [RQ17]
					end
				end
			end
			default: begin
				st_nxt.fsm = spc_pkg::SPC_ST_IDLE;
			end
		endcase

		if (rep_done && (st_r.fsm != spc_pkg::SPC_ST_IDLE)) begin
			if (eie_allowed) begin
				if ((st_r.eie_cnt + 17'h00001) >= eie_intv_eff) begin
					st_nxt.eieosq_insert = 1'b1; // [RQ5]
					st_nxt.eie_cnt = 17'h00000;
				end else begin
					st_nxt.eie_cnt = st_r.eie_cnt + 17'h00001;
				end
			end
			if (sync_allowed) begin
				if ((st_r.sync_cnt + 17'h00001) >= sync_intv_eff) begin
					st_nxt.sync_insert = 1'b1; // [RQ7]
					st_nxt.sync_cnt = 17'h00000;
				end else begin
					st_nxt.sync_cnt = st_r.sync_cnt + 17'h00001;
				end
			end
		end

		if (advance) begin
			st_nxt.block = nb;
			st_nxt.aux_trig = (st_r.fsm == spc_pkg::SPC_ST_IDLE) ? (nb == f_clamp_blk(cfg.trig_block)) :
				(nb == trig_blk_eff); // [RQ11]
			st_nxt.loop_cnt = 20'h00000;
			st_nxt.us_cnt = 20'h00000;
			st_nxt.pre_cnt = 8'h00;
			st_nxt.brk_seen = 1'b0;
			if (st_r.fsm == spc_pkg::SPC_ST_IDLE) begin
				st_nxt.fsm = (nb == f_clamp_blk(cfg.loop_block)) ? spc_pkg::SPC_ST_LOOP : spc_pkg::SPC_ST_RUN;
			end else begin
				st_nxt.fsm = (nb == loop_blk_eff) ? spc_pkg::SPC_ST_LOOP : spc_pkg::SPC_ST_RUN; // [RQ17]
			end
			if (nb == spc_pkg::BLOCK_MIN) begin
				st_nxt.skp_cnt_clr = st_nxt.cfg.skp_rst; // [RQ9]
				if (st_nxt.cfg.eie_rst) begin
					st_nxt.eie_cnt = 17'h00000; // [RQ5]
				end
				if (st_nxt.cfg.sync_rst) begin
					st_nxt.sync_cnt = 17'h00000; // [RQ7]
				end
			end
		end

		st_nxt.loop_active = (st_nxt.fsm == spc_pkg::SPC_ST_LOOP);
		st_nxt.skp_insert_en = st_nxt.tx_led && st_nxt.cfg.skp_ins; // [RQ9]

		if (stop_cmd && (st_r.fsm != spc_pkg::SPC_ST_IDLE)) begin
			st_nxt.fsm = spc_pkg::SPC_ST_IDLE;
			st_nxt.tx_led = 1'b0; // [RQ12]
			st_nxt.loop_active = 1'b0;
			st_nxt.skp_insert_en = 1'b0;
			st_nxt.aux_trig = 1'b0;
			st_nxt.eieosq_insert = 1'b0;
			st_nxt.sync_insert = 1'b0;
			st_nxt.skp_cnt_clr = 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_r <= '0;
		end else if (clk_en) begin
			st_r <= st_nxt;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign tx_led = st_r.tx_led;
	assign loop_active = st_r.loop_active;
	assign cur_block = st_r.block;
	assign aux_trig = st_r.aux_trig;
	assign skp_insert_en = st_r.skp_insert_en;
	assign skp_cnt_clr = st_r.skp_cnt_clr;
	assign eieosq_insert = st_r.eieosq_insert;
	assign sync_insert = st_r.sync_insert;
	assign scr_seed = st_r.scr_seed;
	assign channel_one_seq = st_r.channel_one_seq;
	assign channel_two_seq = st_r.channel_two_seq;
	assign raw_bit_out = st_r.raw_bit_out;

endmodule

// *** sim/spc_rep_model.sv ***
`timescale 1ns/1ps
// Pattern engine stand-in: one repeat finishes every gap+1 cycles while sending.
module spc_rep_model (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic tx_led,
	input wire logic [3:0] gap,
	output logic rep_done
);
	logic [3:0] cnt_r;
	always_ff @(posedge core_clk) begin
		if (rst || !tx_led) begin
			cnt_r <= 4'h0;
			rep_done <= 1'b0;
		end else begin
			rep_done <= (cnt_r == gap);
			cnt_r <= (cnt_r == gap) ? 4'h0 : cnt_r + 4'h1;
		end
	end
endmodule

// *** sim/spc_seq_ctrl_checker.sv ***
`timescale 1ns/1ps
module spc_seq_ctrl_checker (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire spc_pkg::spc_cfg_t cfg,
	input wire logic transmit_cmd,
	input wire logic stop_cmd,
	input wire logic rep_done,
	input wire logic channel_one_seq_req,
	input wire logic channel_two_seq_req,
	input wire logic raw_bit,
	input wire logic raw_is_prbs,
	input wire logic tx_led,
	input wire logic loop_active,
	input wire logic [7:0] cur_block,
	input wire logic aux_trig,
	input wire logic skp_insert_en,
	input wire logic skp_cnt_clr,
	input wire logic eieosq_insert,
	input wire logic sync_insert,
	input wire logic [23:0] scr_seed,
	input wire logic channel_one_seq,
	input wire logic channel_two_seq,
	input wire logic raw_bit_out
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence s_start;
		clk_en && !tx_led && transmit_cmd && !stop_cmd;
	endsequence
	sequence s_stop;
		clk_en && tx_led && stop_cmd;
	endsequence
	a_start_led: assert property (s_start |=> tx_led && cur_block == 8'h01) else $error("start failed");
	a_stop_led: assert property (s_stop |=> !tx_led && !loop_active && !skp_insert_en) else $error("stop failed");
	a_led_holds: assert property (tx_led && !stop_cmd |=> tx_led) else $error("indicator dropped");
	a_trig_pulse: assert property (clk_en && aux_trig && !rep_done |=> !aux_trig) else $error("trigger too long");
	a_trig_block: assert property (aux_trig |-> cur_block == cfg.trig_block) else $error("trigger wrong block");
	a_block_range: assert property (tx_led |-> cur_block inside {[8'h01:8'h80]}) else $error("block out of range");
	a_chan_force: assert property (clk_en |=> channel_one_seq == $past(channel_one_seq_req | channel_two_seq_req)
		&& channel_two_seq == channel_one_seq) else $error("channel forcing wrong");
	a_raw_invert: assert property (clk_en |=> raw_bit_out == $past(raw_bit ^ (raw_is_prbs & cfg.user_prbs_inv)))
		else $error("raw inversion wrong");
	a_skp_clear: assert property (skp_cnt_clr |-> cur_block == 8'h01 && tx_led) else $error("skp clear misplaced");
	a_seed_stable: assert property (tx_led && $past(tx_led) |-> $stable(scr_seed)) else $error("seed moved");
	a_block_step: assert property (tx_led && $past(tx_led) && cur_block != $past(cur_block) |-> $past(rep_done))
		else $error("block moved without repeat");
	a_os_in_tx: assert property (eieosq_insert || sync_insert |-> $past(tx_led)) else $error("set out of run");
endmodule
bind spc_seq_ctrl spc_seq_ctrl_checker i_spc_seq_ctrl_checker (.core_clk, .rst, .clk_en, .cfg, .transmit_cmd,
	.stop_cmd, .rep_done, .channel_one_seq_req, .channel_two_seq_req, .raw_bit, .raw_is_prbs, .tx_led,
	.loop_active, .cur_block, .aux_trig, .skp_insert_en, .skp_cnt_clr, .eieosq_insert, .sync_insert,
	.scr_seed, .channel_one_seq, .channel_two_seq, .raw_bit_out);

// *** sim/spc_seq_ctrl_tb_top.sv ***
`timescale 1ns/1ps
module spc_seq_ctrl_tb_top;
	localparam logic [23:0] LSEED5 = 24'h00A5C3;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic clk_en = 1'b1;
	spc_pkg::spc_cfg_t cfg = '0;
	logic transmit_cmd = 1'b0, stop_cmd = 1'b0, manual_break_cmd = 1'b0, ext_lfps_evt = 1'b0, ext_edge_evt = 1'b0;
	logic channel_one_seq_req = 1'b0, channel_two_seq_req = 1'b0, raw_bit = 1'b0, raw_is_prbs = 1'b0;
	logic [3:0] gap = 4'h3;
	logic rep_done, tx_led, loop_active, aux_trig, skp_insert_en, skp_cnt_clr, eieosq_insert, sync_insert;
	logic channel_one_seq, channel_two_seq, raw_bit_out;
	logic [7:0] cur_block;
	logic [23:0] scr_seed;
	int n_fail = 0, num_checks = 0, n_rep = 0, n_rep2 = 0, n_eie = 0, n_sync = 0;
	always #2.5 core_clk = ~core_clk;
	spc_seq_ctrl #(.LANE_SEED_5(LSEED5)) i_spc_seq_ctrl (.core_clk, .rst, .clk_en, .cfg, .transmit_cmd, .stop_cmd,
		.manual_break_cmd, .ext_lfps_evt, .ext_edge_evt, .rep_done, .channel_one_seq_req, .channel_two_seq_req,
		.raw_bit, .raw_is_prbs, .tx_led, .loop_active, .cur_block, .aux_trig, .skp_insert_en, .skp_cnt_clr,
		.eieosq_insert, .sync_insert, .scr_seed, .channel_one_seq, .channel_two_seq, .raw_bit_out);
	spc_rep_model i_spc_rep_model (.core_clk, .rst, .tx_led, .gap, .rep_done);
	always @(posedge core_clk) begin
		if (rep_done && tx_led) n_rep++;
		if (rep_done && tx_led && cur_block == 8'h02) n_rep2++;
		if (eieosq_insert) n_eie++;
		if (sync_insert) n_sync++;
	end
	task smp;
		@(posedge core_clk);
		#1;
	endtask
	task chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task wblk(input logic [7:0] b, input int lim);
		for (int i = 0; i < lim && cur_block !== b; i++) smp();
		chk("block reached", b, cur_block);
		if (cur_block !== b) tally_and_finish();
	endtask
	task go(input spc_pkg::spc_spec_t sp, input spc_pkg::spc_brk_t bk, input spc_pkg::spc_loop_t lm, input int lv);
		@(posedge core_clk);
		cfg.spec <= sp;
		cfg.brk <= bk;
		cfg.loop_mode <= lm;
		cfg.loop_time <= 20'(lv);
		cfg.loop_num <= 20'(lv);
		cfg.loop_block <= 8'h02;
		cfg.last_block <= 8'h03;
		cfg.trig_block <= 8'h02;
		transmit_cmd <= 1'b1;
		@(posedge core_clk);
		transmit_cmd <= 1'b0;
		#1;
		chk("tx_led on", 1, tx_led);
		chk("first block", 1, cur_block);
	endtask
	task halt;
		@(posedge core_clk);
		stop_cmd <= 1'b1;
		@(posedge core_clk);
		stop_cmd <= 1'b0;
		#1;
		chk("tx_led off", 0, tx_led);
	endtask
	task t_walk;
		int r0, e0, s0;
		@(posedge core_clk);
		cfg.skp_ins <= 1'b1;
		cfg.skp_rst <= 1'b1;
		cfg.eie_ins <= 1'b1;
		cfg.eie_intv <= 17'h00003;
		cfg.sync_ins <= 1'b1;
		cfg.sync_intv <= 17'h00001;
		r0 = n_rep2;
		e0 = n_eie;
		s0 = n_sync;
		go(spc_pkg::SPC_SPEC_PCIE1, spc_pkg::SPC_BRK_OFF, spc_pkg::SPC_LOOP_NUM, 4);
		chk("seed", spc_pkg::SEED_8B10B, scr_seed);
		chk("skp enable", 1, skp_insert_en);
		wblk(8'h02, 20);
		chk("trigger", 1, aux_trig);
		chk("loop on", 1, loop_active);
		wblk(8'h03, 40);
		chk("loop count", 4, 24'(n_rep2 - r0));
		chk("loop off", 0, loop_active);
		wblk(8'h01, 20);
		chk("skp clear", 1, skp_cnt_clr);
		smp();
		halt();
		chk("eieosq count", 2, 24'(n_eie - e0));
		chk("sync count", 0, 24'(n_sync - s0));
		$display("t_walk done");
	endtask
	task t_seed;
		logic [23:0] sd [3];
		sd = '{spc_pkg::SEED_8B10B, LSEED5, spc_pkg::SEED_128B132B};
		for (int k = 0; k < 3; k++) begin
			@(posedge core_clk);
			cfg.coding <= spc_pkg::spc_coding_t'(2'(k));
			cfg.lane <= 3'h5;
			go(spc_pkg::SPC_SPEC_PCIE3, spc_pkg::SPC_BRK_OFF, spc_pkg::SPC_LOOP_NUM, 2);
			chk("seed", sd[k], scr_seed);
			halt();
		end
		$display("t_seed done");
	endtask
	task t_brk(input spc_pkg::spc_brk_t bk, input spc_pkg::spc_spec_t sp, input int w, input logic ex);
		go(sp, bk, spc_pkg::SPC_LOOP_NUM, 2);
		wblk(8'h02, 20);
		@(posedge core_clk);
		manual_break_cmd <= (w == 0);
		ext_lfps_evt <= (w == 1);
		ext_edge_evt <= (w == 2);
		@(posedge core_clk);
		manual_break_cmd <= 1'b0;
		ext_lfps_evt <= 1'b0;
		ext_edge_evt <= 1'b0;
		for (int i = 0; i < 14 && cur_block !== 8'h03; i++) smp();
		chk("break outcome", ex ? 3 : 2, cur_block);
		halt();
		$display("t_brk done");
	endtask
	task t_time;
		int n;
		gap <= 4'h9;
		go(spc_pkg::SPC_SPEC_PCIE1, spc_pkg::SPC_BRK_OFF, spc_pkg::SPC_LOOP_TIME, 2);
		wblk(8'h02, 30);
		for (n = 0; n < 1000 && cur_block === 8'h02; n++) smp();
		chk("loop time low", 1, n >= 399);
		chk("loop time high", 1, n <= 412);
		if (n >= 1000) tally_and_finish();
		halt();
		gap <= 4'h3;
		$display("t_time done");
	endtask
	task t_sync;
		int r0, e0, s0;
		@(posedge core_clk);
		cfg.sync_rst <= 1'b1;
		cfg.sync_intv <= 17'h00002;
		cfg.eie_intv <= 17'h00001;
		r0 = n_rep;
		e0 = n_eie;
		s0 = n_sync;
		go(spc_pkg::SPC_SPEC_USB31G2, spc_pkg::SPC_BRK_OFF, spc_pkg::SPC_LOOP_NUM, 2);
		for (int i = 0; i < 200 && n_rep - r0 < 3; i++) smp();
		chk("repeats seen", 1, n_rep - r0 >= 3);
		if (n_rep - r0 < 3) tally_and_finish();
		halt();
		chk("sync count", 1, 24'(n_sync - s0));
		chk("eieosq count", 0, 24'(n_eie - e0));
		$display("t_sync done");
	endtask
	task t_misc;
		@(posedge core_clk);
		channel_one_seq_req <= 1'b1;
		raw_bit <= 1'b1;
		raw_is_prbs <= 1'b1;
		cfg.user_prbs_inv <= 1'b1;
		smp();
		chk("channel two forced", 1, channel_two_seq);
		chk("raw inverted", 0, raw_bit_out);
		@(posedge core_clk);
		channel_one_seq_req <= 1'b0;
		channel_two_seq_req <= 1'b1;
		cfg.user_prbs_inv <= 1'b0;
		smp();
		chk("channel one forced", 1, channel_one_seq);
		chk("raw plain", 1, raw_bit_out);
		@(posedge core_clk);
		channel_two_seq_req <= 1'b0;
		raw_is_prbs <= 1'b0;
		cfg.user_prbs_inv <= 1'b1;
		smp();
		chk("channel one released", 0, channel_one_seq);
		chk("channel two released", 0, channel_two_seq);
		chk("raw data part plain", 1, raw_bit_out);
		@(posedge core_clk);
		clk_en <= 1'b0;
		channel_one_seq_req <= 1'b1;
		raw_is_prbs <= 1'b1;
		smp();
		chk("frozen channel", 0, channel_two_seq);
		chk("frozen raw", 1, raw_bit_out);
		@(posedge core_clk);
		clk_en <= 1'b1;
		smp();
		chk("thawed channel", 1, channel_two_seq);
		chk("thawed raw", 0, raw_bit_out);
		$display("t_misc done");
	endtask
	initial begin
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		t_walk();
		t_seed();
		t_brk(spc_pkg::SPC_BRK_MANUAL, spc_pkg::SPC_SPEC_PCIE1, 0, 1'b1);
		t_brk(spc_pkg::SPC_BRK_EDGE, spc_pkg::SPC_SPEC_PCIE1, 0, 1'b0);
		t_brk(spc_pkg::SPC_BRK_LFPS, spc_pkg::SPC_SPEC_PCIE1, 1, 1'b0);
		t_brk(spc_pkg::SPC_BRK_LFPS, spc_pkg::SPC_SPEC_USB30, 1, 1'b1);
		t_brk(spc_pkg::SPC_BRK_EDGE, spc_pkg::SPC_SPEC_PCIE1, 2, 1'b1);
		t_time();
		t_sync();
		t_misc();
		tally_and_finish();
	end
endmodule
